// ### exec_tail.sv
// Execution unit tail: multiply, frame release, watchdog refresh, xor
// Summary of operation
// - Multiply 32x32 unsigned; low product to destination, high to source
// - Multiply zero flag set only when whole 64-bit product is zero
// - Multiply sign flag equals product bit 63
// - Frame release: SP gets FP, FP loaded from stack top, SP plus 4
// - Frame release leaves every flag unchanged
// - Watchdog refresh enables a disabled watchdog
// - Further refresh restarts the time-out counter, preventing time-out
// - Opcode FFF7 decodes as watchdog refresh, no operands, no data move
// - Xor writes 1 where destination and source bits differ, else 0
// - Xor never alters the source operand
// - Xor blank flag set when original destination or source was zero
// - Xor flags use memory destination width, 32 bits for registers
`timescale 1ns/100ps
`include "exec_tail_params.svh"
module exec_tail
	import exec_tail_pkg::*;
#(
	parameter logic [31:0] WDOG_CYCLES = `WDOG_TIMEOUT
)
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             wdog_timeout_o
);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	typedef struct packed
	{
		logic        awready;
		logic        wready;
		logic        aw_got;
		logic        w_got;
		logic [7:0]  aw_addr;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [1:0]  size;
		logic        mem_dst;
		logic [15:0] opcode;
		logic [31:0] dst;
		logic [31:0] src;
		logic [31:0] fp;
		logic [31:0] sp;
		logic [31:0] memq;
		logic [7:0]  flags;
		logic [31:0] res_lo;
		logic [31:0] res_hi;
		exec_state_e state;
		op_e         op;
		logic        wd_en;
		logic        wd_to;
		logic [31:0] wd_cnt;
		logic        go;
	} state_s;

	state_s cur_ff;
	state_s nxt_ff;

	logic [63:0] product;
	logic [31:0] xor_res;
	logic        xz;
	logic        xs;
	logic        xb;
	op_e         dec_op;

	assign product = {32'h00000000, cur_ff.dst} * {32'h00000000, cur_ff.src};
	assign xor_res = cur_ff.dst ^ cur_ff.src;

	// Register destinations always evaluate over 32 bits
	flag_eval u_flag_eval
	(
		.res_i   (xor_res),
		.dst_i   (cur_ff.dst),
		.src_i   (cur_ff.src),
		.size_i  (cur_ff.mem_dst ? cur_ff.size : `SZ_QUAD),
		.zero_o  (xz),
		.sign_o  (xs),
		.blank_o (xb)
	);

	// ------------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------------
	always_comb
	begin
		if (cur_ff.opcode == `OPC_WDOG)
			dec_op = watchdog_refresh_op;
		else if (cur_ff.opcode == `OPC_UNLINK)
			dec_op = unlink_op;
		else if (cur_ff.opcode[15:8] == `OPC_UNSIGNED_MULTIPLY_OP_HI)
			dec_op = unsigned_multiply_op;
		else if (cur_ff.opcode[15:8] == `OPC_XOR_HI || cur_ff.mem_dst)
			dec_op = xor_op;
		else
			dec_op = op_none;
	end

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb
	begin
		logic        wr_fire;
		logic [31:0] wmask;
		logic [31:0] wv;
		wr_fire = 1'b0;
		wmask   = {{8{cur_ff.w_strb[3]}}, {8{cur_ff.w_strb[2]}},
		           {8{cur_ff.w_strb[1]}}, {8{cur_ff.w_strb[0]}}};
		wv      = 32'h00000000;
		nxt_ff  = cur_ff;
		nxt_ff.go = 1'b0;

		// Write address and data are taken in either order
		if (s_axi_awvalid && cur_ff.awready)
		begin
			nxt_ff.awready = 1'b0;
			nxt_ff.aw_got  = 1'b1;
			nxt_ff.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && cur_ff.wready)
		begin
			nxt_ff.wready = 1'b0;
			nxt_ff.w_got  = 1'b1;
			nxt_ff.w_data = s_axi_wdata;
			nxt_ff.w_strb = s_axi_wstrb;
		end
		if (cur_ff.bvalid && s_axi_bready)
		begin
			nxt_ff.bvalid  = 1'b0;
			nxt_ff.awready = 1'b1;
			nxt_ff.wready  = 1'b1;
		end

		// Writes land while busy would race the datapath, so they are refused
		if (cur_ff.aw_got && cur_ff.w_got && !cur_ff.bvalid)
		begin
			wr_fire       = 1'b1;
			nxt_ff.aw_got = 1'b0;
			nxt_ff.w_got  = 1'b0;
			nxt_ff.bvalid = 1'b1;
			nxt_ff.bresp  = `AXI_OKAY;
		end

		if (wr_fire && cur_ff.state == st_idle)
		begin
			case (cur_ff.aw_addr)
				`OFS_CTRL:
				begin
					wv = cur_ff.w_data;
					if (cur_ff.w_strb[0])
					begin
						nxt_ff.size    = wv[`CTRL_SZ_MSB:`CTRL_SZ_LSB];
						nxt_ff.mem_dst = wv[`CTRL_MEMD_BIT];
						nxt_ff.go      = wv[`CTRL_GO_BIT];
					end
				end
				`OFS_OPCODE:
					nxt_ff.opcode = (cur_ff.opcode & ~wmask[15:0]) | (cur_ff.w_data[15:0] & wmask[15:0]);
				`OFS_DST:   nxt_ff.dst  = (cur_ff.dst & ~wmask) | (cur_ff.w_data & wmask);
				`OFS_SRC:   nxt_ff.src  = (cur_ff.src & ~wmask) | (cur_ff.w_data & wmask);
				`OFS_FP:    nxt_ff.fp   = (cur_ff.fp & ~wmask) | (cur_ff.w_data & wmask);
				`OFS_SP:    nxt_ff.sp   = (cur_ff.sp & ~wmask) | (cur_ff.w_data & wmask);
				`OFS_MEMQ:  nxt_ff.memq = (cur_ff.memq & ~wmask) | (cur_ff.w_data & wmask);
				`OFS_FLAGS:
					if (cur_ff.w_strb[0])
						nxt_ff.flags = cur_ff.w_data[7:0];
				default:    nxt_ff.bresp = `AXI_SLVERR;
			endcase
		end
		else if (wr_fire)
			nxt_ff.bresp = `AXI_SLVERR;

		// Read channel
		if (cur_ff.rvalid && s_axi_rready)
		begin
			nxt_ff.rvalid  = 1'b0;
			nxt_ff.arready = 1'b1;
		end
		if (s_axi_arvalid && cur_ff.arready)
		begin
			nxt_ff.arready = 1'b0;
			nxt_ff.rvalid  = 1'b1;
			nxt_ff.rresp   = `AXI_OKAY;
			case (s_axi_araddr)
				`OFS_CTRL:     nxt_ff.rdata = {28'h0000000, cur_ff.mem_dst, cur_ff.size, 1'b0};
				`OFS_OPCODE:   nxt_ff.rdata = {16'h0000, cur_ff.opcode};
				`OFS_DST:      nxt_ff.rdata = cur_ff.dst;
				`OFS_SRC:      nxt_ff.rdata = cur_ff.src;
				`OFS_FP:       nxt_ff.rdata = cur_ff.fp;
				`OFS_SP:       nxt_ff.rdata = cur_ff.sp;
				`OFS_MEMQ:     nxt_ff.rdata = cur_ff.memq;
				`OFS_FLAGS:    nxt_ff.rdata = {24'h000000, cur_ff.flags};
				`OFS_STATUS:   nxt_ff.rdata = {29'h00000000, cur_ff.wd_to, cur_ff.wd_en,
				                               cur_ff.state != st_idle};
				`OFS_RES_LO:   nxt_ff.rdata = cur_ff.res_lo;
				`OFS_RES_HI:   nxt_ff.rdata = cur_ff.res_hi;
				`OFS_WDOG_CNT: nxt_ff.rdata = cur_ff.wd_cnt;
				default:
				begin
					nxt_ff.rdata = `RST_WORD;
					nxt_ff.rresp = `AXI_SLVERR;
				end
			endcase
		end

		// Watchdog counter; time-out is sticky until the next refresh or reset
		if (cur_ff.wd_en && !cur_ff.wd_to)
		begin
			if (cur_ff.wd_cnt == WDOG_CYCLES - 32'h00000001)
				nxt_ff.wd_to = 1'b1;
			else
				nxt_ff.wd_cnt = cur_ff.wd_cnt + 32'h00000001;
		end

		// Execution sequencer
		case (cur_ff.state)
			st_idle:
				if (cur_ff.go)
				begin
					nxt_ff.op    = dec_op;
					nxt_ff.state = st_exec;
				end
			st_exec:
			begin
				nxt_ff.state = st_done;
				case (cur_ff.op)
					unsigned_multiply_op:
					begin
						nxt_ff.dst    = product[31:0];
						nxt_ff.src    = product[63:32];
						nxt_ff.res_lo = product[31:0];
						nxt_ff.res_hi = product[63:32];
						nxt_ff.flags[`FLG_Z] = (product == 64'h0000000000000000);
						nxt_ff.flags[`FLG_S] = product[63];
						nxt_ff.flags[`FLG_V] = 1'b0;
						nxt_ff.flags[`FLG_B] = 1'b0;
					end
					unlink_op:
					begin
						// Stack top word supplied in memq; flags untouched
						nxt_ff.fp     = cur_ff.memq;
						nxt_ff.sp     = cur_ff.fp + `SP_STEP;
						nxt_ff.res_lo = cur_ff.fp;
						nxt_ff.res_hi = `RST_WORD;
					end
					watchdog_refresh_op:
					begin
						// Refresh moves no data and touches no flag
						nxt_ff.wd_en  = 1'b1;
						nxt_ff.wd_cnt = `RST_WORD;
						nxt_ff.wd_to  = 1'b0;
					end
					xor_op:
					begin
						// Source register is never rewritten
						nxt_ff.dst    = xor_res;
						nxt_ff.res_lo = xor_res;
						nxt_ff.res_hi = `RST_WORD;
						nxt_ff.flags[`FLG_Z] = xz;
						nxt_ff.flags[`FLG_S] = xs;
						nxt_ff.flags[`FLG_V] = 1'b0;
						nxt_ff.flags[`FLG_B] = xb;
					end
					default:
						nxt_ff.state = st_done;
				endcase
			end
			st_done:
				nxt_ff.state = st_idle;
			default:
				nxt_ff.state = st_idle;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cur_ff         <= '0;
			cur_ff.awready <= 1'b1;
			cur_ff.wready  <= 1'b1;
			cur_ff.arready <= 1'b1;
			cur_ff.state   <= st_idle;
			cur_ff.op      <= op_none;
			cur_ff.flags   <= `RST_FLAGS;
		end
		else
			cur_ff <= nxt_ff;
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign s_axi_awready  = cur_ff.awready;
	assign s_axi_wready   = cur_ff.wready;
	assign s_axi_bvalid   = cur_ff.bvalid;
	assign s_axi_bresp    = cur_ff.bresp;
	assign s_axi_arready  = cur_ff.arready;
	assign s_axi_rvalid   = cur_ff.rvalid;
	assign s_axi_rdata    = cur_ff.rdata;
	assign s_axi_rresp    = cur_ff.rresp;
	assign wdog_timeout_o = cur_ff.wd_to;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	// Product rebuilt from the operands as they stood during execution
	chk_mul_result: assert property (@(posedge clk_i) disable iff (rst_i)
		cur_ff.state == st_exec && cur_ff.op == unsigned_multiply_op |=>
		{cur_ff.src, cur_ff.dst} ==
		{32'h00000000, $past(cur_ff.dst)} * {32'h00000000, $past(cur_ff.src)})
		else $error("multiply result misplaced");

	// Unsigned product is zero exactly when either operand was zero
	chk_mul_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		cur_ff.state == st_exec && cur_ff.op == unsigned_multiply_op |=>
		cur_ff.flags[`FLG_Z] ==
		($past(cur_ff.dst) == 32'h00000000 || $past(cur_ff.src) == 32'h00000000))
		else $error("multiply zero flag wrong");

	// High product word sits in the source register, checked above
	chk_mul_sign: assert property (@(posedge clk_i) disable iff (rst_i)
		cur_ff.state == st_exec && cur_ff.op == unsigned_multiply_op |=>
		cur_ff.flags[`FLG_S] == cur_ff.src[31])
		else $error("multiply sign flag wrong");

	chk_mul_kept: assert property (@(posedge clk_i) disable iff (rst_i)
		cur_ff.state == st_exec && cur_ff.op == unsigned_multiply_op |=>
		!cur_ff.flags[`FLG_V] && !cur_ff.flags[`FLG_B] &&
		cur_ff.flags[2:0] == $past(cur_ff.flags[2:0]) &&
		cur_ff.flags[`FLG_C] == $past(cur_ff.flags[`FLG_C]))
		else $error("multiply flag side effects wrong");

	chk_unlink_sp: assert property (@(posedge clk_i) disable iff (rst_i)
		cur_ff.state == st_exec && cur_ff.op == unlink_op |=>
		cur_ff.sp == $past(cur_ff.fp) + `SP_STEP && cur_ff.fp == $past(cur_ff.memq))
		else $error("frame release pointers wrong");

	chk_unlink_flags: assert property (@(posedge clk_i) disable iff (rst_i)
		cur_ff.state == st_exec && cur_ff.op == unlink_op |=> $stable(cur_ff.flags))
		else $error("frame release changed flags");

	chk_wdog_enable: assert property (@(posedge clk_i) disable iff (rst_i)
		cur_ff.state == st_exec && cur_ff.op == watchdog_refresh_op |=>
		cur_ff.wd_en && cur_ff.wd_cnt == 32'h00000000 && !wdog_timeout_o)
		else $error("watchdog refresh ineffective");

	chk_wdog_decode: assert property (@(posedge clk_i) disable iff (rst_i)
		cur_ff.state == st_idle && cur_ff.go && cur_ff.opcode == `OPC_WDOG |=>
		cur_ff.op == watchdog_refresh_op ##1 $stable(cur_ff.dst) && $stable(cur_ff.src))
		else $error("refresh opcode mishandled");

	chk_xor_result: assert property (@(posedge clk_i) disable iff (rst_i)
		cur_ff.state == st_exec && cur_ff.op == xor_op |=>
		cur_ff.dst == ($past(cur_ff.dst) ^ $past(cur_ff.src)) && $stable(cur_ff.src))
		else $error("xor result wrong");

	chk_xor_flags: assert property (@(posedge clk_i) disable iff (rst_i)
		cur_ff.state == st_exec && cur_ff.op == xor_op && !cur_ff.mem_dst |=>
		cur_ff.flags[`FLG_Z] == (cur_ff.dst == 32'h00000000) &&
		cur_ff.flags[`FLG_S] == cur_ff.dst[31] && !cur_ff.flags[`FLG_V] &&
		cur_ff.flags[`FLG_B] == ($past(cur_ff.dst) == 32'h0 || cur_ff.src == 32'h0))
		else $error("xor register flags wrong");

endmodule // exec_tail

// ### exec_tail_params.svh
// Constants for the execution tail unit
`ifndef EXEC_TAIL_PARAMS_SVH
`define EXEC_TAIL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Bus register offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL       8'h00
`define OFS_OPCODE     8'h04
`define OFS_DST        8'h08
`define OFS_SRC        8'h0C
`define OFS_FP         8'h10
`define OFS_SP         8'h14
`define OFS_MEMQ       8'h18
`define OFS_FLAGS      8'h1C
`define OFS_STATUS     8'h20
`define OFS_RES_LO     8'h24
`define OFS_RES_HI     8'h28
`define OFS_WDOG_CNT   8'h2C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTRL_GO_BIT    0
`define CTRL_SZ_LSB    1
`define CTRL_SZ_MSB    2
`define CTRL_MEMD_BIT  3
`define FLG_C          7
`define FLG_Z          6
`define FLG_S          5
`define FLG_V          4
`define FLG_B          3
`define FLG_CURRENT_IRQ_ENABLE_FLAG      1
`define FLG_MASTER_IRQ_ENABLE_FLAG       0
`define STS_BUSY_BIT   0
`define STS_WDEN_BIT   1
`define STS_WDTO_BIT   2

// ----------------------------------------------------------------------------
// Opcodes, sizes, reset values, timing
// ----------------------------------------------------------------------------
`define OPC_WDOG       16'hFFF7
`define OPC_UNLINK     16'h0001
`define OPC_UNSIGNED_MULTIPLY_OP_HI    8'hB0
`define OPC_XOR_HI     8'hA4
`define SZ_BYTE        2'h0
`define SZ_WORD        2'h1
`define SZ_QUAD        2'h2
`define SP_STEP        32'h00000004
`define RST_WORD       32'h00000000
`define RST_FLAGS      8'h00
`define AXI_OKAY       2'h0
`define AXI_SLVERR     2'h2
`define WDOG_TIMEOUT   32'h000F4240

`endif

// ### exec_tail_pkg.sv
// Types shared by the execution tail unit
package exec_tail_pkg;

	typedef enum logic [2:0]
	{
		op_none,
		unsigned_multiply_op,
		unlink_op,
		watchdog_refresh_op,
		xor_op
	} op_e;

	typedef enum logic [1:0]
	{
		st_idle,
		st_exec,
		st_done
	} exec_state_e;

endpackage

// ### flag_eval.sv
// Sized zero and sign evaluation of an ALU result, blank of its operands
`timescale 1ns/100ps
`include "exec_tail_params.svh"
module flag_eval
	import exec_tail_pkg::*;
(
	input  wire logic [31:0] res_i,
	input  wire logic [31:0] dst_i,
	input  wire logic [31:0] src_i,
	input  wire logic [1:0]  size_i,
	output logic             zero_o,
	output logic             sign_o,
	output logic             blank_o
);

	logic [31:0] mask;

	always_comb
	begin
		case (size_i)
			`SZ_BYTE: mask = 32'h000000FF;
			`SZ_WORD: mask = 32'h0000FFFF;
			default:  mask = 32'hFFFFFFFF;
		endcase
		zero_o  = ((res_i & mask) == 32'h00000000);
		blank_o = ((dst_i & mask) == 32'h00000000) || ((src_i & mask) == 32'h00000000);
		case (size_i)
			`SZ_BYTE: sign_o = res_i[7];
			`SZ_WORD: sign_o = res_i[15];
			default:  sign_o = res_i[31];
		endcase
	end

endmodule // flag_eval

// ### stack_mem.sv
// Data memory model holding the quads read from the stack top
`timescale 1ns/100ps
module stack_mem
#(
	parameter int DEPTH = 256
)
(
	input  wire logic [31:0] addr_i,
	output logic      [31:0] data_o
);
	// ----
	// Storage
	// ----
	logic [31:0] mem [DEPTH];

	initial
	begin
		for (int k = 0; k < DEPTH; k++)
			mem[k] = {8'(k), 8'hC3, ~8'(k), 8'h5A};
	end

	// Quads are aligned, so the low two address bits are dropped
	assign data_o = mem[addr_i[9:2]];
endmodule // stack_mem

// ### testbench.sv
// Self-checking bench for the execution tail unit
`timescale 1ns/100ps
`include "exec_tail_params.svh"
`define CHK(g, e) \
	begin \
		n_tests++; \
		if ((g) !== (e)) \
		begin \
			bad_count++; \
			$display("Error at %0t: got %h expected %h", $time, g, e); \
		end \
	end
module testbench;
	logic        clk_i, rst_i;
	logic [7:0]  awaddr, araddr, f;
	logic [31:0] wdata, rdata, mem_word, d, s, fp, dv;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, wdog_to;
	logic [1:0]  bresp, rresp, sz, r;
	logic [63:0] p;
	logic [31:0] cd [3] = '{32'hFFFFFFFF, 32'h00000002, 32'h00000000};
	logic [31:0] cs [3] = '{32'hFFFFFFFF, 32'h80000000, 32'h12345678};
	int          bad_count = 0;
	int          n_tests = 0;
	int          cyc = 0;

	// Short watchdog count keeps the run brief
	exec_tail #(.WDOG_CYCLES(32'h00000040)) u_dut
	(
		.clk_i          (clk_i),
		.rst_i          (rst_i),
		.s_axi_awaddr   (awaddr),
		.s_axi_awvalid  (awvalid),
		.s_axi_awready  (awready),
		.s_axi_wdata    (wdata),
		.s_axi_wstrb    (4'hF),
		.s_axi_wvalid   (wvalid),
		.s_axi_wready   (wready),
		.s_axi_bresp    (bresp),
		.s_axi_bvalid   (bvalid),
		.s_axi_bready   (bready),
		.s_axi_araddr   (araddr),
		.s_axi_arvalid  (arvalid),
		.s_axi_arready  (arready),
		.s_axi_rdata    (rdata),
		.s_axi_rresp    (rresp),
		.s_axi_rvalid   (rvalid),
		.s_axi_rready   (rready),
		.wdog_timeout_o (wdog_to)
	);

	stack_mem u_mem
	(
		.addr_i (fp),
		.data_o (mem_word)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// ----
	// Bus tasks and expectations
	// ----
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		logic aw;
		logic w;
		@(posedge clk_i);
		aw = 1'b1;
		w = 1'b1;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw || w)
		begin
			@(posedge clk_i);
			aw = aw && (awready !== 1'b1);
			w = w && (wready !== 1'b1);
			awvalid <= aw;
			wvalid <= w;
		end
		while (bvalid !== 1'b1)
			@(posedge clk_i);
		bready <= 1'b0;
		`CHK(bresp, er)
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge clk_i);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1)
			@(posedge clk_i);
		v = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		rd(a, dv, r);
		`CHK(dv, e)
	endtask

	// Busy clears three edges after the start, then poll for safety
	task automatic run(input logic [15:0] op, input logic [3:0] ctl);
		logic [31:0] st;
		logic [1:0]  rr;
		wr(`OFS_OPCODE, {16'h0000, op}, `AXI_OKAY);
		wr(`OFS_CTRL, {28'h0000000, ctl | 4'h1}, `AXI_OKAY);
		repeat (4) @(posedge clk_i);
		st = 32'h00000001;
		while (st[`STS_BUSY_BIT] !== 1'b0)
			rd(`OFS_STATUS, st, rr);
	endtask

	task automatic load(input logic [31:0] a, input logic [31:0] b, input logic [7:0] k);
		wr(`OFS_DST, a, `AXI_OKAY);
		wr(`OFS_SRC, b, `AXI_OKAY);
		wr(`OFS_FLAGS, {24'h000000, k}, `AXI_OKAY);
	endtask

	function automatic logic [7:0] mflags(input logic [63:0] q, input logic [7:0] k);
		return (k & 8'h83) | {1'b0, q == 64'h0, q[63], 5'h00};
	endfunction

	function automatic logic [7:0] xflags(input logic [31:0] a, input logic [31:0] b,
		input logic [1:0] z, input logic m, input logic [7:0] k);
		logic [31:0] msk;
		logic [31:0] q;
		msk = (!m || z == `SZ_QUAD) ? 32'hFFFFFFFF : (z == `SZ_WORD) ? 32'h0000FFFF : 32'h000000FF;
		q = (a ^ b) & msk;
		return (k & 8'h83) | {1'b0, q == 32'h0, |(q & (msk ^ (msk >> 1))), 1'b0,
			(a & msk) == 32'h0 || (b & msk) == 32'h0, 3'h0};
	endfunction

	task automatic print_verdict();
		$display("Checks: %0d, mismatches: %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Hang guard well above the expected run length
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			bad_count++;
			print_verdict();
		end
	end

	// ----
	// Main sequence
	// ----
	initial
	begin
		rst_i = 1'b1;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		void'($urandom(32'h488E));
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		chk_rd(`OFS_FLAGS, 32'h00000000);
		chk_rd(`OFS_STATUS, 32'h00000000);
		`CHK(wdog_to, 1'b0)
		for (int i = 0; i < 10; i++)
		begin
			d = (i < 3) ? cd[i] : $urandom;
			s = (i < 3) ? cs[i] : $urandom;
			f = 8'($urandom) & 8'hFB;
			p = {32'h0, d} * {32'h0, s};
			load(d, s, f);
			run(16'hB054, 4'h0);
			chk_rd(`OFS_DST, p[31:0]);
			chk_rd(`OFS_SRC, p[63:32]);
			chk_rd(`OFS_FLAGS, {24'h000000, mflags(p, f)});
		end
		for (int i = 0; i < 12; i++)
		begin
			sz = 2'(i % 3);
			d = (i % 4 == 1) ? ($urandom & 32'hFFFF0000) : $urandom;
			s = (i == 4) ? 32'h00000000 : $urandom;
			f = 8'($urandom) & 8'hFB;
			load(d, s, f);
			run(16'hA454, {i[0], sz, 1'b0});
			chk_rd(`OFS_DST, d ^ s);
			chk_rd(`OFS_SRC, s);
			chk_rd(`OFS_FLAGS, {24'h000000, xflags(d, s, sz, i[0], f)});
		end
		for (int i = 0; i < 4; i++)
		begin
			fp = $urandom & 32'hFFFFFFFC;
			f = 8'($urandom) & 8'hFB;
			wr(`OFS_FP, fp, `AXI_OKAY);
			wr(`OFS_SP, $urandom, `AXI_OKAY);
			wr(`OFS_FLAGS, {24'h000000, f}, `AXI_OKAY);
			wr(`OFS_MEMQ, mem_word, `AXI_OKAY);
			run(16'h0001, 4'h0);
			chk_rd(`OFS_SP, fp + `SP_STEP);
			chk_rd(`OFS_FP, mem_word);
			chk_rd(`OFS_FLAGS, {24'h000000, f});
		end
		chk_rd(`OFS_STATUS, 32'h00000000);
		wr(`OFS_DST, 32'h5A5A0F0F, `AXI_OKAY);
		run(`OPC_WDOG, 4'h0);
		chk_rd(`OFS_STATUS, 32'h00000002);
		chk_rd(`OFS_DST, 32'h5A5A0F0F);
		for (int i = 0; i < 4; i++)
		begin
			repeat (20) @(posedge clk_i);
			run(`OPC_WDOG, 4'h0);
			`CHK(wdog_to, 1'b0)
		end
		repeat (80) @(posedge clk_i);
		`CHK(wdog_to, 1'b1)
		run(`OPC_WDOG, 4'h0);
		`CHK(wdog_to, 1'b0)
		rd(8'h30, dv, r);
		`CHK({r, dv}, {`AXI_SLVERR, 32'h00000000})
		wr(`OFS_RES_LO, 32'h00000001, `AXI_SLVERR);
		wr(8'h3C, 32'h00000001, `AXI_SLVERR);
		print_verdict();
	end
endmodule // testbench
